/* File: common/ata_cmd_pkg.sv */
// Shared constants and types for the ATA command interpreter block
package ata_cmd_pkg;
   // Command codes
   localparam logic [7:0] CMD_DIAG = 8'h90;
   localparam logic [7:0] CMD_FLUSH = 8'he7;
   localparam logic [7:0] CMD_FORMAT = 8'h50;
   localparam logic [7:0] CMD_IDENT = 8'hec;
   // Diagnostic result codes and the abort error code
   localparam logic [7:0] DIAG_OK = 8'h01;
   localparam logic [7:0] DIAG_FMT = 8'h02;
   localparam logic [7:0] DIAG_BUF = 8'h03;
   localparam logic [7:0] DIAG_ECC = 8'h04;
   localparam logic [7:0] DIAG_CPU = 8'h05;
   localparam logic [7:0] DIAG_SLAVE = 8'h80;
   localparam logic [7:0] ERR_ABORT = 8'h04;
   // Field positions
   localparam int DRV_BIT = 4;
   localparam int LBA_BIT = 6;
   // Sector geometry, identify words and format pattern
   localparam int SECTOR_WORDS = 256;
   localparam logic [15:0] ID_W5 = 16'h0200;
   localparam int W_CFG = 0;
   localparam int W_CYL = 1;
   localparam int W_HEADS = 3;
   localparam int W_W5 = 5;
   localparam int W_SPT = 6;
   localparam int W_CAP_HI = 7;
   localparam int W_CAP_LO = 8;
   localparam int W_SN_FIRST = 10;
   localparam int W_SN_LAST = 19;
   localparam logic [15:0] FORMAT_PATTERN = 16'hffff;
   // Reset values
   localparam logic [7:0] ERR_RST = 8'h00;

   typedef struct packed {
      logic [7:0] command;
      logic [7:0] sector_count;
      logic [7:0] drive_head;
   } task_file_t;

   typedef struct packed {
      logic busy;
      logic ready;
      logic seek_complete_flag;
      logic drq;
      logic err;
   } status_t;

   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_DIAG = 7'b0000010,
      ST_FLUSH = 7'b0000100,
      ST_IDENT = 7'b0001000,
      ST_FMT_RX = 7'b0010000,
      ST_FMT_WR = 7'b0100000,
      ST_DONE = 7'b1000000
   } state_t;
endpackage : ata_cmd_pkg

/* File: rtl/ata_cmd.sv */
// Command interpreter and data FIFO for the ATA task-file command block
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   output logic [WIDTH-1:0] rd_data_out,
   output logic rd_valid_out,
   input wire logic rd_ready_in
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_r;
   logic [AW:0] rd_ptr_r;
   logic do_wr;
   logic do_rd;

   assign wr_ready_out = (wr_ptr_r - rd_ptr_r) != (AW+1)'(DEPTH);
   assign rd_valid_out = wr_ptr_r != rd_ptr_r;
   assign rd_data_out = mem[rd_ptr_r[AW-1:0]];
   assign do_wr = wr_valid_in && wr_ready_out;
   assign do_rd = rd_valid_out && rd_ready_in;

   always_ff @(posedge clk_in) begin
      if (do_wr) begin
         mem[wr_ptr_r[AW-1:0]] <= wr_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end
endmodule : word_fifo

module ata_cmd #(
   parameter logic [15:0] CFG_CARD = 16'h1234,  // Arbitrary value
   parameter logic [15:0] CFG_FIXED = 16'h5678, // Arbitrary value
   parameter logic [15:0] CYLINDERS = 16'h0100,
   parameter logic [15:0] HEADS = 16'h0010,
   parameter logic [15:0] SPT = 16'h0020,
   parameter logic [31:0] CAPACITY = 32'h00020000,
   parameter logic [159:0] SERIAL = {20{8'h20}},
   parameter bit FLUSH_SUPPORTED = 1'b1,
   parameter bit IS_SLAVE = 1'b0,
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Configuration straps
   input wire logic fixed_disk_mode_in,
   // Command issue
   input wire ata_cmd_pkg::task_file_t tf_in,
   input wire logic cmd_strobe_in,
   // Self-test and slave results
   input wire logic [3:0] selftest_fail_in,
   input wire logic slave_fail_in,
   // Write cache and media interface
   output logic flush_req_out,
   input wire logic cache_empty_in,
   output logic [7:0] fmt_count_out,
   output logic [15:0] media_data_out,
   output logic media_valid_out,
   input wire logic media_ready_in,
   // Host data port
   output logic [15:0] rd_data_out,
   output logic rd_valid_out,
   input wire logic rd_ready_in,
   input wire logic [15:0] wr_data_in,
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   // Result
   output ata_cmd_pkg::status_t status_out,
   output logic [7:0] error_out,
   output logic intrq_out
);
   ata_cmd_pkg::state_t state_r;
   logic [8:0] word_cnt_r;
   logic [8:0] fmt_left_r;
   logic [7:0] error_r;
   logic intrq_r;
   logic flush_r;
   logic [7:0] fmt_count_r;
   logic [15:0] media_data_r;
   logic media_valid_r;
   logic [1:0] mode_sync_r;
   logic [1:0] cache_sync_r;
   logic [15:0] id_word;
   logic [15:0] fifo_out;
   logic fifo_valid;
   logic fifo_in_ready;
   logic fifo_push;
   logic drive_sel;
   logic [15:0] rd_data_r;
   logic rd_valid_r;
   logic [7:0] diag_code;
   logic [3:0] sn_idx;
   logic [8:0] id_idx;

   // Mode strap and cache status come from outside this domain
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         mode_sync_r <= 2'b00;
         cache_sync_r <= 2'b00;
      end else begin
         mode_sync_r <= {mode_sync_r[0], fixed_disk_mode_in};
         cache_sync_r <= {cache_sync_r[0], cache_empty_in};
      end
   end

   assign drive_sel = tf_in.drive_head[ata_cmd_pkg::DRV_BIT];

   // Self-test faults are prioritised lowest unit first
   always_comb begin
      diag_code = ata_cmd_pkg::DIAG_OK;
      if (selftest_fail_in[0]) begin
         diag_code = ata_cmd_pkg::DIAG_FMT;
      end else if (selftest_fail_in[1]) begin
         diag_code = ata_cmd_pkg::DIAG_BUF;
      end else if (selftest_fail_in[2]) begin
         diag_code = ata_cmd_pkg::DIAG_ECC;
      end else if (selftest_fail_in[3]) begin
         diag_code = ata_cmd_pkg::DIAG_CPU;
      end else if (mode_sync_r[1] && slave_fail_in) begin
         diag_code = ata_cmd_pkg::DIAG_SLAVE | 8'h01;
      end
   end

   // Look one word ahead on an accept, so the reload is the next word
   assign id_idx = word_cnt_r + 9'(rd_valid_r && rd_ready_in);
   assign sn_idx = 4'(id_idx - 9'(ata_cmd_pkg::W_SN_FIRST));

   // Identify sector contents; unlisted words read zero
   always_comb begin
      id_word = 16'h0000;
      case (id_idx)
         9'(ata_cmd_pkg::W_CFG): id_word = mode_sync_r[1] ? CFG_FIXED
                                                         : CFG_CARD;
         9'(ata_cmd_pkg::W_CYL): id_word = CYLINDERS;
         9'(ata_cmd_pkg::W_HEADS): id_word = HEADS;
         9'(ata_cmd_pkg::W_W5): id_word = ata_cmd_pkg::ID_W5;
         9'(ata_cmd_pkg::W_SPT): id_word = SPT;
         9'(ata_cmd_pkg::W_CAP_HI): id_word = CAPACITY[31:16];
         9'(ata_cmd_pkg::W_CAP_LO): id_word = CAPACITY[15:0];
         default: begin
            if (id_idx >= 9'(ata_cmd_pkg::W_SN_FIRST) &&
                id_idx <= 9'(ata_cmd_pkg::W_SN_LAST)) begin
               id_word = SERIAL[(9 - sn_idx) * 16 +: 16];
            end
         end
      endcase
   end

   // Host write data of format passes through the FIFO
   assign fifo_push = wr_valid_in && wr_ready_out &&
                      state_r == ata_cmd_pkg::ST_FMT_RX;

   word_fifo #(
      .WIDTH(16),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .wr_data_in(wr_data_in),
      .wr_valid_in(fifo_push),
      .wr_ready_out(fifo_in_ready),
      .rd_data_out(fifo_out),
      .rd_valid_out(fifo_valid),
      .rd_ready_in(1'b1) // Buffer data is dropped unused
   );

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         wr_ready_out <= 1'b0;
      end else begin
         // Drop ready only once the last word is taken; a gap in host
         // valid before the last word must not stall the sector
         wr_ready_out <= fifo_in_ready &&
                         state_r == ata_cmd_pkg::ST_FMT_RX &&
                         !(fifo_push && word_cnt_r ==
                           9'(ata_cmd_pkg::SECTOR_WORDS - 1));
      end
   end

   // Main sequencer
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_r <= ata_cmd_pkg::ST_IDLE;
         word_cnt_r <= '0;
         fmt_left_r <= '0;
         error_r <= ata_cmd_pkg::ERR_RST;
      end else begin
         case (state_r)
            ata_cmd_pkg::ST_IDLE: begin
               word_cnt_r <= '0;
               if (cmd_strobe_in &&
                   (mode_sync_r[1] || drive_sel == IS_SLAVE)) begin
                  error_r <= ata_cmd_pkg::ERR_RST;
                  case (tf_in.command)
                     ata_cmd_pkg::CMD_DIAG:
                        state_r <= ata_cmd_pkg::ST_DIAG;
                     ata_cmd_pkg::CMD_FLUSH: begin
                        if (FLUSH_SUPPORTED) begin
                           state_r <= ata_cmd_pkg::ST_FLUSH;
                        end else begin
                           error_r <= ata_cmd_pkg::ERR_ABORT;
                           state_r <= ata_cmd_pkg::ST_DONE;
                        end
                     end
                     ata_cmd_pkg::CMD_IDENT:
                        state_r <= ata_cmd_pkg::ST_IDENT;
                     ata_cmd_pkg::CMD_FORMAT: begin
                        state_r <= ata_cmd_pkg::ST_FMT_RX;
                        if (tf_in.drive_head[ata_cmd_pkg::LBA_BIT]) begin
                           fmt_left_r <= (tf_in.sector_count == 8'h00) ?
                              9'h100 : {1'b0, tf_in.sector_count};
                        end else begin
                           fmt_left_r <= 9'h001;
                        end
                     end
                     default: state_r <= ata_cmd_pkg::ST_IDLE;
                  endcase
               end
            end
            ata_cmd_pkg::ST_DIAG: begin
               error_r <= diag_code;
               state_r <= ata_cmd_pkg::ST_DONE;
            end
            ata_cmd_pkg::ST_FLUSH: begin
               if (cache_sync_r[1]) begin
                  state_r <= ata_cmd_pkg::ST_DONE;
               end
            end
            ata_cmd_pkg::ST_IDENT: begin
               if (rd_valid_r && rd_ready_in) begin
                  if (word_cnt_r == 9'(ata_cmd_pkg::SECTOR_WORDS - 1)) begin
                     state_r <= ata_cmd_pkg::ST_DONE;
                  end
                  word_cnt_r <= word_cnt_r + 9'h001;
               end
            end
            ata_cmd_pkg::ST_FMT_RX: begin
               if (fifo_push && wr_ready_out) begin
                  if (word_cnt_r == 9'(ata_cmd_pkg::SECTOR_WORDS - 1)) begin
                     word_cnt_r <= '0;
                     state_r <= ata_cmd_pkg::ST_FMT_WR;
                  end else begin
                     word_cnt_r <= word_cnt_r + 9'h001;
                  end
               end
            end
            ata_cmd_pkg::ST_FMT_WR: begin
               if (media_valid_r && media_ready_in) begin
                  if (word_cnt_r == 9'(ata_cmd_pkg::SECTOR_WORDS - 1)) begin
                     word_cnt_r <= '0;
                     fmt_left_r <= fmt_left_r - 9'h001;
                     if (fmt_left_r == 9'h001) begin
                        state_r <= ata_cmd_pkg::ST_DONE;
                     end
                  end else begin
                     word_cnt_r <= word_cnt_r + 9'h001;
                  end
               end
            end
            ata_cmd_pkg::ST_DONE: state_r <= ata_cmd_pkg::ST_IDLE;
            default: state_r <= ata_cmd_pkg::ST_IDLE;
         endcase
      end
   end

   // Identify read port registered; held until the host takes it
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rd_data_r <= 16'h0000;
         rd_valid_r <= 1'b0;
      end else if (state_r == ata_cmd_pkg::ST_IDENT &&
                   (!rd_valid_r || rd_ready_in) &&
                   !(rd_valid_r && word_cnt_r ==
                     9'(ata_cmd_pkg::SECTOR_WORDS - 1))) begin
         rd_valid_r <= 1'b1;
         rd_data_r <= id_word;
      end else if (rd_ready_in) begin
         rd_valid_r <= 1'b0;
      end
   end

   assign rd_data_out = rd_data_r;
   assign rd_valid_out = rd_valid_r;

   // Media side: flush request and format pattern
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         flush_r <= 1'b0;
         media_valid_r <= 1'b0;
         media_data_r <= 16'h0000;
         fmt_count_r <= 8'h00;
      end else begin
         flush_r <= state_r == ata_cmd_pkg::ST_FLUSH;
         media_valid_r <= state_r == ata_cmd_pkg::ST_FMT_WR &&
                          !(media_valid_r && media_ready_in &&
                            word_cnt_r ==
                            9'(ata_cmd_pkg::SECTOR_WORDS - 1) &&
                            fmt_left_r == 9'h001);
         media_data_r <= ata_cmd_pkg::FORMAT_PATTERN;
         fmt_count_r <= fmt_left_r[7:0];
      end
   end

   // Status and interrupt
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         intrq_r <= 1'b0;
         status_out <= '0;
      end else begin
         intrq_r <= state_r == ata_cmd_pkg::ST_DONE ||
                    (state_r == ata_cmd_pkg::ST_IDENT &&
                     word_cnt_r == 9'h000 && !rd_valid_r);
         status_out.busy <= state_r != ata_cmd_pkg::ST_IDLE &&
                            state_r != ata_cmd_pkg::ST_DONE &&
                            state_r != ata_cmd_pkg::ST_IDENT &&
                            !(state_r == ata_cmd_pkg::ST_FMT_RX);
         status_out.ready <= 1'b1;
         status_out.seek_complete_flag <= 1'b1;
         status_out.drq <= state_r == ata_cmd_pkg::ST_IDENT ||
                           state_r == ata_cmd_pkg::ST_FMT_RX;
         status_out.err <= error_r == ata_cmd_pkg::ERR_ABORT &&
                           state_r != ata_cmd_pkg::ST_DIAG;
      end
   end

   assign error_out = error_r;
   assign intrq_out = intrq_r;
   assign flush_req_out = flush_r;
   assign media_valid_out = media_valid_r;
   assign media_data_out = media_data_r;
   assign fmt_count_out = fmt_count_r;

   a_flush_wait: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      state_r == ata_cmd_pkg::ST_FLUSH && !cache_sync_r[1]
      |=> state_r == ata_cmd_pkg::ST_FLUSH)
      else $error("flush ended before cache empty");
   a_diag_code: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      state_r == ata_cmd_pkg::ST_DIAG |=> error_r == $past(diag_code))
      else $error("diagnostic code not stored");
   a_diag_ok: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      state_r == ata_cmd_pkg::ST_DIAG && selftest_fail_in == 4'h0 &&
      !mode_sync_r[1] |=> error_r == ata_cmd_pkg::DIAG_OK)
      else $error("wrong no-error code");
   a_done_irq: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      state_r == ata_cmd_pkg::ST_DONE |=> intrq_r && !status_out.busy)
      else $error("no interrupt at completion");
   a_fmt_pattern: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      media_valid_r |-> media_data_r == ata_cmd_pkg::FORMAT_PATTERN)
      else $error("format pattern wrong");
   a_id_gap_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      id_idx == 9'h002 || id_idx > 9'(ata_cmd_pkg::W_SN_LAST)
      |-> id_word == 16'h0000)
      else $error("reserved identify word nonzero");
   a_fmt_count: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      state_r == ata_cmd_pkg::ST_IDLE && cmd_strobe_in &&
      (mode_sync_r[1] || drive_sel == IS_SLAVE) &&
      tf_in.command == ata_cmd_pkg::CMD_FORMAT &&
      tf_in.drive_head[ata_cmd_pkg::LBA_BIT] && tf_in.sector_count == 8'h00
      |=> fmt_left_r == 9'h100)
      else $error("zero sector count not 256");
   a_card_select: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      state_r == ata_cmd_pkg::ST_IDLE && cmd_strobe_in && !mode_sync_r[1] &&
      drive_sel != IS_SLAVE |=> state_r == ata_cmd_pkg::ST_IDLE)
      else $error("unselected card ran a command");
endmodule : ata_cmd

`default_nettype wire

/* File: dv/host_model.sv */
// Host-side data model: drains identify words and sources a format sector
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Read stream from the card
   input wire logic [15:0] rd_data_in,
   input wire logic rd_valid_in,
   output logic rd_ready_out,
   // Write stream to the card
   input wire logic send_in,
   input wire logic wr_ready_in,
   output logic [15:0] wr_data_out,
   output logic wr_valid_out,
   // Progress
   output logic [15:0] rx_count_out,
   output logic [15:0] tx_count_out
);
   logic [15:0] words [0:255];
   logic [1:0] phase_r;
   // Stall one cycle in four so the card sees back-pressure
   assign rd_ready_out = (phase_r != 2'h1);
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         phase_r <= 2'h0;
         rx_count_out <= 16'h0000;
      end else begin
         phase_r <= phase_r + 2'h1;
         if (rd_valid_in && rd_ready_out) begin
            words[rx_count_out[7:0]] <= rd_data_in;
            rx_count_out <= rx_count_out + 16'h0001;
         end
      end
   end
   // One whole sector, each word held until taken; data inverts after
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !send_in) begin
         tx_count_out <= 16'h0000;
         wr_valid_out <= 1'b0;
         wr_data_out <= 16'h0000;
      end else if (wr_valid_out) begin
         if (wr_ready_in) begin
            tx_count_out <= tx_count_out + 16'h0001;
            wr_valid_out <= 1'b0;
            wr_data_out <= ~wr_data_out;
         end
      end else if (tx_count_out < 16'h0100 && phase_r != 2'h3) begin
         wr_valid_out <= 1'b1;
         wr_data_out <= 16'h5a00 ^ tx_count_out;
      end
   end
endmodule : host_model
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the ATA command interpreter
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [15:0] CFG = 16'h3c21; // Arbitrary value
   localparam logic [15:0] CYL = 16'h01f3;
   localparam logic [15:0] HDS = 16'h000b;
   localparam logic [15:0] SPT = 16'h003f;
   localparam logic [31:0] CAP = 32'h0012_3456;
   localparam logic [159:0] SER = {{12{8'h20}}, 64'h534e_3030_3030_3432};
   logic clk_in, rst_n_in, fixed, strobe, slv, cache_empty, media_rdy;
   logic send, rd_valid, rd_ready, wr_valid, wr_ready, flush_req;
   logic media_valid, irq, irq2;
   logic [3:0] fail;
   logic [7:0] fmt_count, err, err2;
   logic [15:0] media_data, rd_data, wr_data, rx_n, tx_n;
   ata_cmd_pkg::task_file_t tf;
   ata_cmd_pkg::status_t st, st2;
   int err_count, tests_run, media_n, media_bad, n;
   logic [3:0] fail_tab [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h6};
   logic [7:0] code_tab [6] = '{ata_cmd_pkg::DIAG_OK, ata_cmd_pkg::DIAG_FMT,
      ata_cmd_pkg::DIAG_BUF, ata_cmd_pkg::DIAG_ECC, ata_cmd_pkg::DIAG_CPU,
      ata_cmd_pkg::DIAG_BUF};

   ata_cmd #(.CFG_CARD(CFG), .CYLINDERS(CYL), .HEADS(HDS), .SPT(SPT),
      .CAPACITY(CAP), .SERIAL(SER)) i_ata_cmd (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .fixed_disk_mode_in(fixed),
      .tf_in(tf), .cmd_strobe_in(strobe), .selftest_fail_in(fail),
      .slave_fail_in(slv), .flush_req_out(flush_req),
      .cache_empty_in(cache_empty), .fmt_count_out(fmt_count),
      .media_data_out(media_data), .media_valid_out(media_valid),
      .media_ready_in(media_rdy), .rd_data_out(rd_data),
      .rd_valid_out(rd_valid), .rd_ready_in(rd_ready), .wr_data_in(wr_data),
      .wr_valid_in(wr_valid), .wr_ready_out(wr_ready), .status_out(st),
      .error_out(err), .intrq_out(irq));
   // Second card without flush support, watched only for the flush command
   ata_cmd #(.FLUSH_SUPPORTED(1'b0)) i_ata_cmd_noflush (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .fixed_disk_mode_in(fixed),
      .tf_in(tf), .cmd_strobe_in(strobe), .selftest_fail_in(fail),
      .slave_fail_in(slv), .flush_req_out(), .cache_empty_in(cache_empty),
      .fmt_count_out(), .media_data_out(), .media_valid_out(),
      .media_ready_in(media_rdy), .rd_data_out(), .rd_valid_out(),
      .rd_ready_in(rd_ready), .wr_data_in(wr_data), .wr_valid_in(wr_valid),
      .wr_ready_out(), .status_out(st2), .error_out(err2), .intrq_out(irq2));
   host_model i_host_model (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .rd_data_in(rd_data), .rd_valid_in(rd_valid), .rd_ready_out(rd_ready),
      .send_in(send), .wr_ready_in(wr_ready), .wr_data_out(wr_data),
      .wr_valid_out(wr_valid), .rx_count_out(rx_n), .tx_count_out(tx_n));

   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   // Media side stalls every other cycle
   always @(posedge clk_in) begin
      #1 media_rdy = ~media_rdy;
   end
   always @(posedge clk_in) begin
      if (rst_n_in && media_valid && media_rdy) begin
         media_n++;
         if (media_data !== ata_cmd_pkg::FORMAT_PATTERN) media_bad++;
      end
   end

   task automatic check(input string name, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s exp %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic tick(input int k);
      repeat (k) @(posedge clk_in);
      #1;
   endtask : tick
   task automatic issue(input logic [7:0] c, sc, dh);
      tf = {c, sc, dh};
      strobe = 1'b1;
      tick(1);
      strobe = 1'b0;
   endtask : issue
   // Waits for the interrupt pulse, bounded
   task automatic wait_irq(input int lim);
      n = 0;
      while (irq !== 1'b1 && n < lim) begin
         tick(1);
         n++;
      end
      check("intrq", {31'h0, irq}, 32'h1);
   endtask : wait_irq
   function automatic logic [15:0] id_exp(input int k);
      case (k)
         0: return CFG;
         1: return CYL;
         3: return HDS;
         5: return ata_cmd_pkg::ID_W5;
         6: return SPT;
         7: return CAP[31:16];
         8: return CAP[15:0];
         default: return (k >= 10) ? SER[159-16*(k-10) -: 16] : 16'h0000;
      endcase
   endfunction : id_exp
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict

   initial begin
      repeat (20000) @(posedge clk_in);
      err_count++;
      print_verdict();
   end

   initial begin
      {rst_n_in, fixed, strobe, slv, cache_empty, media_rdy, send} = 7'h0;
      fail = 4'h0;
      tf = '0;
      tick(10);
      check("busy_rst", {31'h0, st.busy}, 32'h0);
      rst_n_in = 1'b1;
      tick(3);
      check("ready_rst", {31'h0, st.ready}, 32'h1);
      for (int i = 0; i < 6; i++) begin
         fail = fail_tab[i];
         issue(ata_cmd_pkg::CMD_DIAG, 8'h5a, 8'hef);
         wait_irq(10);
         check("diag_code", {24'h0, err}, {24'h0, code_tab[i]});
         check("diag_busy", {31'h0, st.busy}, 32'h0);
      end
      fail = 4'h0;
      // Card mode, other drive selected: must stay silent
      issue(ata_cmd_pkg::CMD_DIAG, 8'h00, 8'h10);
      n = 0;
      repeat (10) begin
         tick(1);
         if (irq === 1'b1) n++;
      end
      check("diag_unsel", n, 32'h0);
      fixed = 1'b1;
      slv = 1'b1;
      tick(4);
      issue(ata_cmd_pkg::CMD_DIAG, 8'h00, 8'h10);
      wait_irq(10);
      check("diag_slave", {24'h0, err}, 32'h81);
      fixed = 1'b0;
      slv = 1'b0;
      tick(4);
      issue(ata_cmd_pkg::CMD_FLUSH, 8'h00, 8'h00);
      tick(1);
      check("noflush_irq", {31'h0, irq2}, 32'h1);
      check("noflush_err", {24'h0, err2},
         {24'h0, ata_cmd_pkg::ERR_ABORT});
      check("noflush_st", {31'h0, st2.err}, 32'h1);
      tick(10);
      check("flush_req", {31'h0, flush_req}, 32'h1);
      check("flush_busy", {30'h0, st.busy, irq}, 32'h2);
      cache_empty = 1'b1;
      wait_irq(20);
      check("flush_st", {29'h0, st.busy, st.ready, st.seek_complete_flag},
         32'h3);
      issue(ata_cmd_pkg::CMD_IDENT, 8'h00, 8'h00);
      n = 0;
      while (rx_n < 16'h0100 && n < 2000) begin
         tick(1);
         n++;
      end
      wait_irq(10);
      check("ident_n", rx_n, 32'h100);
      for (int k = 0; k < 20; k++)
         check("ident", i_host_model.words[k], id_exp(k));
      n = 0;
      for (int k = 20; k < 256; k++)
         if (i_host_model.words[k] !== 16'h0000) n++;
      check("ident_rsv", n, 32'h0);
      // LBA format of two sectors, then CHS format of one
      // Hosts are advised against format, yet it must still work
      for (int j = 0; j < 2; j++) begin
         media_n = 0;
         media_bad = 0;
         issue(ata_cmd_pkg::CMD_FORMAT, 8'h02, j == 0 ? 8'h40 : 8'h00);
         tick(1);
         check("fmt_cnt", fmt_count, j == 0 ? 32'h2 : 32'h1);
         send = 1'b1;
         wait_irq(4000);
         send = 1'b0;
         check("fmt_rx", tx_n, 32'h100);
         check("fmt_len", media_n, j == 0 ? 32'h200 : 32'h100);
         check("fmt_pat", media_bad, 32'h0);
      end
      // Zero LBA count means 256 sectors; cut short by a mid-run reset
      issue(ata_cmd_pkg::CMD_FORMAT, 8'h00, 8'h40);
      tick(1);
      check("fmt_256", {23'h0, i_ata_cmd.fmt_left_r}, 32'h100);
      check("fmt_drq", {30'h0, st.drq, st.busy}, 32'h2);
      rst_n_in = 1'b0;
      tick(2);
      check("rst_mid", {29'h0, st.drq, wr_ready, irq}, 32'h0);
      rst_n_in = 1'b1;
      tick(3);
      check("rst_rdy", {30'h0, st.ready, st.busy}, 32'h2);
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
